// ---- rtl/sgpd_map.svh ----
// constants for the segment and page descriptor decoder
`ifndef SGPD_MAP_SVH
`define SGPD_MAP_SVH
`define SGPD_SEG_REGS        16
`define SGPD_SEG_IDX_W       4
// 32-bit segment register, bit 0 is msb (big-endian numbering)
`define SGPD_SR_FMT_BIT      31
`define SGPD_SR_SKEY_BIT     30
`define SGPD_SR_UKEY_BIT     29
`define SGPD_SR_NOEX_BIT     28
`define SGPD_SR_VIRTUAL_SEGMENT_IDENTIFIER_W       24
`define SGPD_SR_BUS_UNIT_IDENTIFIER_HI      28
`define SGPD_SR_BUS_UNIT_IDENTIFIER_LO      20
`define SGPD_SR_CTRL_W       20
`define SGPD_SR_PAGE_MASK    32'hF0FFFFFF
`define SGPD_SR_RESET        32'h00000000
// 64-bit table base and group address
`define SGPD_TB_MASK         64'hFFFFFFFFFFFFF000
`define SGPD_TB_RESET        64'h0000000000000000
`define SGPD_GRP_HASH_W      5
`define SGPD_GRP_ZERO_W      7
// page table entry fields, lsb-numbered
`define SGPD_VSID64_W        52
`define SGPD_API64_W         5
`define SGPD_API32_W         6
`define SGPD_PPN64_W         52
`define SGPD_PPN32_W         20
`define SGPD_MIN_HASH64      11
`endif

// ---- rtl/sgpd_pkg.sv ----
// types for the segment and page descriptor decoder
package sgpd_pkg;
    typedef enum logic [1:0] {
        SGPD_OP_NONE,
        SGPD_OP_WRITE,
        SGPD_OP_READ
    } sgpd_op_e;
    typedef enum logic [1:0] {
        SGPD_ST_IDLE,
        SGPD_ST_DONE,
        SGPD_ST_FAULT
    } sgpd_state_e;
endpackage

// ---- rtl/sgpd_pte_match.sv ----
// page table entry matcher and field decoder (64-bit or 32-bit format)
`timescale 1ns/1ns
`include "sgpd_map.svh"
module sgpd_pte_match #(
    parameter int WIDE = 1
) (
    input  wire logic [127:0] entry_in,
    input  wire logic [51:0]  virtual_segment_identifier_in,
    input  wire logic [5:0]   api_in,
    input  wire logic         hash_in,
    output logic              hit_out,
    output logic [51:0]       ppn_out,
    output logic              ref_out,
    output logic              chg_out,
    output logic [3:0]        cache_mode_out,
    output logic [1:0]        prot_out
);
    // msb-first bit n of a 64-bit doubleword is index 63-n
    logic [63:0] dw0;
    logic [63:0] dw1;
    logic        v;
    logic        h;
    logic [51:0] vs;
    logic [5:0]  abbreviated_page_index;
    always_comb begin
        dw0 = entry_in[127:64];
        dw1 = entry_in[63:0];
        if (WIDE != 0) begin
            v   = dw0[0];                                   // RULE_17
            h   = dw0[1];                                   // RULE_17
            vs  = dw0[63:12];                               // RULE_17
            abbreviated_page_index = {1'b0, dw0[11:7]};                        // RULE_17 RULE_19
            ppn_out        = dw1[63:12];                    // RULE_18
            ref_out        = dw1[8];                        // RULE_18 RULE_22
            chg_out        = dw1[7];                        // RULE_18 RULE_22
            cache_mode_out = dw1[6:3];                      // RULE_18
            prot_out       = dw1[1:0];                      // RULE_18
        end else begin
            // 32-bit entry: two words in the low 64 bits
            v   = dw1[63];                                  // RULE_20
            vs  = {28'h0000000, dw1[62:39]};                // RULE_20
            h   = dw1[38];                                  // RULE_20
            abbreviated_page_index = dw1[37:32];                               // RULE_20
            ppn_out        = {32'h00000000, dw1[31:12]};    // RULE_21
            ref_out        = dw1[8];                        // RULE_22
            chg_out        = dw1[7];                        // RULE_22
            cache_mode_out = dw1[6:3];
            prot_out       = dw1[1:0];
        end
        hit_out = v && (vs == virtual_segment_identifier_in) && (h == hash_in) && (abbreviated_page_index == api_in); // RULE_16
    end
endmodule

// ---- rtl/sgpd_top.sv ----
// segment descriptor registers, table base, descriptor and page entry decode
// How it works
// RULE_01 - 64-bit segment entry second doubleword: identifier in bits 0-51, rest reserved.
// RULE_02 - segment identifier forms the high bits of the virtual page number.
// RULE_03 - supervisor and user keys combine with page protection for access rights.
// RULE_04 - table base holds address bits 0-51; bits 52-63 reserved.
// RULE_05 - group address bits 52-56 from hash, bits 57-63 zero.
// RULE_06 - software keeps the table 4 Kbyte aligned and valid when translating.
// RULE_07 - unsupported base bits should be zero; a set one flags a machine check.
// RULE_08 - software avoids bases zero, 0x1000 and 0x2000.
// RULE_09 - sixteen 32-bit segment descriptor registers on chip.
// RULE_10 - page segment register: format, keys, no-execute, reserved, identifier fields.
// RULE_11 - segment register moves allowed only in supervisor mode.
// RULE_12 - indirect moves select register from operand bits 0-3.
// RULE_13 - format bit one: direct-store with bus unit id and controller data.
// RULE_14 - 64-bit direct-store entry passes whole second doubleword through.
// RULE_15 - page entries are 128 bits wide or 64 bits wide.
// RULE_16 - hit needs identifier, hash id, valid and abbreviated index all matching.
// RULE_17 - 64-bit entry first doubleword field layout.
// RULE_18 - 64-bit entry second doubleword field layout.
// RULE_19 - abbreviated index omits at least 11 hashed low-order bits.
// RULE_20 - 32-bit entry first word field layout.
// RULE_21 - 32-bit entry second word: page number, reserved bits.
// RULE_22 - referenced and changed bits record page usage history.
// RULE_23 - recently used segment entries may be kept in a lookaside buffer.
// RULE_24 - reserved descriptor bits ignored on decode and read back as zero.
`timescale 1ns/1ns
`include "sgpd_map.svh"
module sgpd_top
    import sgpd_pkg::*;
#(
    parameter int PA_BITS   = 64,
    parameter int WIDE_PTE  = 1
) (
    input  wire logic         clk_sys_in,
    input  wire logic         nrst_in,
    // segment register move port
    input  wire logic         sr_req_in,
    input  wire logic         sr_write_in,
    input  wire logic         sr_indirect_in,
    input  wire logic [3:0]   sr_num_in,
    input  wire logic [31:0]  sr_rb_in,
    input  wire logic [31:0]  sr_wdata_in,
    input  wire logic         supervisor_in,
    output logic              sr_ack_out,
    output logic              sr_priv_fault_out,
    output logic [31:0]       sr_rdata_out,
    // table base pointer
    input  wire logic         tb_wr_in,
    input  wire logic [63:0]  tb_wdata_in,
    output logic [63:0]       tb_out,
    output logic              machine_check_out,
    // segment lookup (32-bit design)
    input  wire logic         xlate_req_in,
    input  wire logic [31:0]  eff_addr_in,
    output logic              xlate_valid_out,
    output logic              direct_store_out,
    output logic              seg_skey_out,
    output logic              seg_ukey_out,
    output logic              seg_noexec_out,
    output logic [8:0]        bus_unit_id_out,
    output logic [19:0]       ctrl_data_out,
    output logic [39:0]       vpn32_out,
    // 64-bit segment table entry second doubleword and group address
    input  wire logic [63:0]  ste_dw1_in,
    input  wire logic         ste_direct_in,
    input  wire logic [4:0]   ste_hash_in,
    output logic [51:0]       ste_virtual_segment_identifier_out,
    output logic [63:0]       ste_dev_data_out,
    output logic [63:0]       group_addr_out,
    // page table entry check
    input  wire logic         pte_req_in,
    input  wire logic [127:0] pte_in,
    input  wire logic [5:0]   pte_api_in,
    input  wire logic         pte_hash_in,
    input  wire logic         access_store_in,
    output logic              pte_hit_out,
    output logic [51:0]       ppn_out,
    output logic [3:0]        cache_mode_out,
    output logic              access_ok_out,
    output logic              pte_upd_out,
    output logic              pte_ref_out,
    output logic              pte_chg_out
);
    // elaboration-time refusal of widths the masks cannot serve
    if (PA_BITS < 13 || PA_BITS > 64) begin : g_bad_pa
        $error("PA_BITS out of range");
    end
    if (WIDE_PTE < 0 || WIDE_PTE > 1) begin : g_bad_wide
        $error("WIDE_PTE must be 0 or 1");
    end

    // =========================================================
    // storage
    logic [31:0] seg_q [`SGPD_SEG_REGS];                    // RULE_09
    logic [63:0] tb_q;
    logic [63:0] pa_mask;
    sgpd_state_e st_q;
    logic [3:0]  sel;

    function automatic logic [31:0] sr_clean(input logic [31:0] d);
        // reserved bits of a page-format descriptor read as zero
        sr_clean = d[`SGPD_SR_FMT_BIT] ? d : (d & `SGPD_SR_PAGE_MASK); // RULE_24
    endfunction

    always_comb begin
        // bit 0 of rb is its msb, so bits 0-3 are [31:28]
        sel = sr_indirect_in ? sr_rb_in[31:28] : sr_num_in; // RULE_12
        pa_mask = (PA_BITS == 64) ? 64'hFFFFFFFFFFFFFFFF : ~(64'hFFFFFFFFFFFFFFFF << PA_BITS);
    end

    // =========================================================
    // segment register moves
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < `SGPD_SEG_REGS; i++) begin
                seg_q[i] <= `SGPD_SR_RESET;
            end
        end else if (sr_req_in && sr_write_in && supervisor_in) begin // RULE_11
            seg_q[sel] <= sr_clean(sr_wdata_in);            // RULE_24
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_q              <= SGPD_ST_IDLE;
            sr_ack_out        <= 1'b0;
            sr_priv_fault_out <= 1'b0;
            sr_rdata_out      <= 32'h00000000;
        end else begin
            sr_ack_out        <= sr_req_in && supervisor_in;
            sr_priv_fault_out <= sr_req_in && !supervisor_in; // RULE_11
            case (st_q)
                SGPD_ST_IDLE: begin
                    if (sr_req_in) begin
                        st_q <= supervisor_in ? SGPD_ST_DONE : SGPD_ST_FAULT;
                    end
                end
                default: begin
                    st_q <= sr_req_in ? (supervisor_in ? SGPD_ST_DONE : SGPD_ST_FAULT) : SGPD_ST_IDLE;
                end
            endcase
            if (sr_req_in && !sr_write_in && supervisor_in) begin
                sr_rdata_out <= sr_clean(seg_q[sel]);       // RULE_24
            end
        end
    end

    // =========================================================
    // table base pointer
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tb_q              <= `SGPD_TB_RESET;
            tb_out            <= `SGPD_TB_RESET;
            machine_check_out <= 1'b0;
        end else begin
            if (tb_wr_in) begin
                tb_q   <= tb_wdata_in & `SGPD_TB_MASK;      // RULE_04
                tb_out <= tb_wdata_in & `SGPD_TB_MASK;      // RULE_04
                // bits beyond the physical width raise a sticky check
                if ((tb_wdata_in & `SGPD_TB_MASK & ~pa_mask) != 64'h0) begin
                    machine_check_out <= 1'b1;              // RULE_07
                end
            end
        end
    end

    // =========================================================
    // segment lookup and 64-bit entry decode
    logic [31:0] sd;
    always_comb begin
        // no separate lookaside copy: sixteen registers are already one-cycle reads
        sd = seg_q[eff_addr_in[31:28]];                     // RULE_23
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            xlate_valid_out  <= 1'b0;
            direct_store_out <= 1'b0;
            seg_skey_out     <= 1'b0;
            seg_ukey_out     <= 1'b0;
            seg_noexec_out   <= 1'b0;
            bus_unit_id_out  <= 9'h000;
            ctrl_data_out    <= 20'h00000;
            vpn32_out        <= 40'h0000000000;
            ste_virtual_segment_identifier_out     <= 52'h0000000000000;
            ste_dev_data_out <= 64'h0000000000000000;
            group_addr_out   <= 64'h0000000000000000;
        end else begin
            xlate_valid_out <= xlate_req_in;
            if (xlate_req_in) begin
                direct_store_out <= sd[`SGPD_SR_FMT_BIT];   // RULE_10 RULE_13
                seg_skey_out     <= sd[`SGPD_SR_SKEY_BIT];  // RULE_10 RULE_03
                seg_ukey_out     <= sd[`SGPD_SR_UKEY_BIT];  // RULE_10 RULE_03
                seg_noexec_out   <= sd[`SGPD_SR_FMT_BIT] ? 1'b0 : sd[`SGPD_SR_NOEX_BIT]; // RULE_10
                bus_unit_id_out  <= sd[`SGPD_SR_FMT_BIT] ? sd[`SGPD_SR_BUS_UNIT_IDENTIFIER_HI:`SGPD_SR_BUS_UNIT_IDENTIFIER_LO] : 9'h000; // RULE_13
                ctrl_data_out    <= sd[`SGPD_SR_FMT_BIT] ? sd[19:0] : 20'h00000; // RULE_13
                // identifier then page index from address bits 4-19
                vpn32_out <= {sd[23:0], eff_addr_in[27:12]}; // RULE_02 RULE_10
            end
            ste_virtual_segment_identifier_out     <= ste_direct_in ? 52'h0 : ste_dw1_in[63:12]; // RULE_01 RULE_24
            ste_dev_data_out <= ste_direct_in ? ste_dw1_in : 64'h0;        // RULE_14
            group_addr_out   <= {tb_q[63:12], ste_hash_in, 7'h00};         // RULE_05
        end
    end

    // =========================================================
    // page table entry check and history update
    logic        m_hit;
    logic [51:0] m_ppn;
    logic        m_ref;
    logic        m_chg;
    logic [3:0]  m_cache_mode_bits;
    logic [1:0]  m_pp;
    logic        key;
    logic        ok;

    sgpd_pte_match #(
        .WIDE (WIDE_PTE)
    ) u_match (
        .entry_in       (pte_in),                           // RULE_15
        .virtual_segment_identifier_in        (WIDE_PTE != 0 ? ste_virtual_segment_identifier_out : {28'h0, vpn32_out[39:16]}),
        .api_in         (WIDE_PTE != 0 ? {1'b0, vpn32_out[15:11]} : vpn32_out[15:10]),
        .hash_in        (pte_hash_in),
        .hit_out        (m_hit),
        .ppn_out        (m_ppn),
        .ref_out        (m_ref),
        .chg_out        (m_chg),
        .cache_mode_out (m_cache_mode_bits),
        .prot_out       (m_pp)
    );

    always_comb begin
        // key chosen by privilege, then combined with page protection
        key = supervisor_in ? seg_skey_out : seg_ukey_out;  // RULE_03
        case ({key, m_pp})
            3'b000, 3'b001, 3'b010: ok = 1'b1;
            3'b011:                 ok = !access_store_in;
            3'b100:                 ok = 1'b0;
            3'b101, 3'b111:         ok = !access_store_in;
            3'b110:                 ok = 1'b1;
            default:                ok = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pte_hit_out    <= 1'b0;
            ppn_out        <= 52'h0000000000000;
            cache_mode_out <= 4'h0;
            access_ok_out  <= 1'b0;
            pte_upd_out    <= 1'b0;
            pte_ref_out    <= 1'b0;
            pte_chg_out    <= 1'b0;
        end else begin
            pte_hit_out   <= pte_req_in && m_hit;           // RULE_16
            access_ok_out <= pte_req_in && m_hit && ok;     // RULE_03
            if (pte_req_in && m_hit) begin
                ppn_out        <= m_ppn;
                cache_mode_out <= m_cache_mode_bits;
                pte_ref_out    <= 1'b1;                     // RULE_22
                pte_chg_out    <= m_chg || (access_store_in && ok); // RULE_22
                pte_upd_out    <= !m_ref || (access_store_in && ok && !m_chg); // RULE_22
            end else begin
                pte_upd_out <= 1'b0;
            end
        end
    end
endmodule

// ---- sim/sgpd_assertions.sv ----
// port checker for the segment and page descriptor decoder
`timescale 1ns/1ns
module sgpd_checker #(
    parameter int PA_BITS = 64
) (
    input wire logic         clk_sys_in,
    input wire logic         nrst_in,
    input wire logic         sr_req_in,
    input wire logic         sr_write_in,
    input wire logic         supervisor_in,
    input wire logic         sr_ack_out,
    input wire logic         sr_priv_fault_out,
    input wire logic [31:0]  sr_rdata_out,
    input wire logic         tb_wr_in,
    input wire logic [63:0]  tb_wdata_in,
    input wire logic [63:0]  tb_out,
    input wire logic         machine_check_out,
    input wire logic         xlate_req_in,
    input wire logic [31:0]  eff_addr_in,
    input wire logic         xlate_valid_out,
    input wire logic [39:0]  vpn32_out,
    input wire logic [63:0]  ste_dw1_in,
    input wire logic         ste_direct_in,
    input wire logic [4:0]   ste_hash_in,
    input wire logic [51:0]  ste_virtual_segment_identifier_out,
    input wire logic [63:0]  ste_dev_data_out,
    input wire logic [63:0]  group_addr_out,
    input wire logic         pte_req_in,
    input wire logic         pte_hit_out,
    input wire logic         pte_upd_out,
    input wire logic         pte_ref_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);
    // ===========================================================
    // register moves
    property p_user_fault; sr_req_in && !supervisor_in |=> sr_priv_fault_out && !sr_ack_out; endproperty
    a_user_fault: assert property (p_user_fault) else $error("user move not refused");
    property p_sup_ack; sr_req_in && supervisor_in |=> sr_ack_out && !sr_priv_fault_out; endproperty
    a_sup_ack: assert property (p_sup_ack) else $error("supervisor move not acknowledged");
    property p_rsvd_zero; sr_ack_out && !$past(sr_write_in) && !sr_rdata_out[31] |-> sr_rdata_out[27:24] == 4'h0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved read bits not zero");
    // ===========================================================
    // table base, group address and segment table entry
    property p_tb_load; tb_wr_in |=> tb_out == {$past(tb_wdata_in[63:12]), 12'h000}; endproperty
    a_tb_load: assert property (p_tb_load) else $error("table base load wrong");
    property p_mc_set; tb_wr_in && (tb_wdata_in >> PA_BITS) != 64'h0 |=> machine_check_out; endproperty
    a_mc_set: assert property (p_mc_set) else $error("machine check not raised");
    property p_mc_stick; machine_check_out |=> machine_check_out; endproperty
    a_mc_stick: assert property (p_mc_stick) else $error("machine check dropped");
    property p_group; 1'h1 |=> group_addr_out[11:0] == {$past(ste_hash_in), 7'h00}; endproperty
    a_group: assert property (p_group) else $error("group address low bits wrong");
    property p_ste; 1'h1 |=> ste_dev_data_out == ($past(ste_direct_in) ? $past(ste_dw1_in) : 64'h0); endproperty
    a_ste: assert property (p_ste) else $error("device data wrong");
    property p_vsid64; !ste_direct_in |=> ste_virtual_segment_identifier_out == $past(ste_dw1_in[63:12]); endproperty
    a_vsid64: assert property (p_vsid64) else $error("segment entry identifier wrong");
    // ===========================================================
    // lookup and page entry check
    property p_vpn; xlate_req_in |=> xlate_valid_out && vpn32_out[15:0] == $past(eff_addr_in[27:12]); endproperty
    a_vpn: assert property (p_vpn) else $error("page number low part wrong");
    property p_hit_cause; !pte_req_in |=> !pte_hit_out && !pte_upd_out; endproperty
    a_hit_cause: assert property (p_hit_cause) else $error("hit without request");
    property p_hist; pte_upd_out |-> pte_ref_out; endproperty
    a_hist: assert property (p_hist) else $error("write-back without referenced");
    c_fault: cover property (sr_req_in && !supervisor_in);
    c_mc: cover property (machine_check_out);
    c_hit: cover property (pte_hit_out && pte_upd_out);
endmodule
bind sgpd_top sgpd_checker #(.PA_BITS(PA_BITS)) u_chk (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .sr_req_in(sr_req_in), .sr_write_in(sr_write_in), .supervisor_in(supervisor_in), .sr_ack_out(sr_ack_out),
    .sr_priv_fault_out(sr_priv_fault_out), .sr_rdata_out(sr_rdata_out), .tb_wr_in(tb_wr_in),
    .tb_wdata_in(tb_wdata_in), .tb_out(tb_out), .machine_check_out(machine_check_out),
    .xlate_req_in(xlate_req_in), .eff_addr_in(eff_addr_in), .xlate_valid_out(xlate_valid_out),
    .vpn32_out(vpn32_out), .ste_dw1_in(ste_dw1_in), .ste_direct_in(ste_direct_in), .ste_hash_in(ste_hash_in),
    .ste_virtual_segment_identifier_out(ste_virtual_segment_identifier_out), .ste_dev_data_out(ste_dev_data_out), .group_addr_out(group_addr_out),
    .pte_req_in(pte_req_in), .pte_hit_out(pte_hit_out), .pte_upd_out(pte_upd_out), .pte_ref_out(pte_ref_out));

// ---- sim/sgpd_table_model.sv ----
// behavioural page and segment table contents in memory
`timescale 1ns/1ns
module sgpd_table_model (
    input  wire logic [1:0]   idx_in,
    input  wire logic [51:0]  virtual_segment_identifier_in,
    input  wire logic [4:0]   api_in,
    output logic [127:0]      pte_out,
    output logic [63:0]       ste_dw1_out
);
    // ===========================================================
    // entry 0 rw unused, 1 invalid, 2 other hash, 3 referenced read-only
    logic       v, h, r;
    logic [1:0] pp;
    always_comb begin
        v = (idx_in != 2'h1);
        h = (idx_in == 2'h2);
        r = (idx_in == 2'h3);
        pp = (idx_in == 2'h3) ? 2'h3 : 2'h2;
        pte_out = {virtual_segment_identifier_in, api_in, 5'h00, h, v, 50'h1_2345_6789, idx_in, 3'h0, r, 1'h0, 4'h5, 1'h0, pp};
        // entry 3 doubles as a direct-store segment entry with device data
        ste_dw1_out = {virtual_segment_identifier_in, (idx_in == 2'h3) ? 12'hC5A : 12'h000};
    end
endmodule

// ---- sim/tb_segment_page_descriptor_decode.sv ----
// self-checking bench for the segment and page descriptor decoder
`timescale 1ns/1ns
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("Error %s expected %0h seen %0h", what, exp, got); end end
module tb_segment_page_descriptor_decode;
    logic         clk_sys_in = 1'h0, nrst_in = 1'h0, sr_req = 1'h0, sr_write = 1'h0, sr_ind = 1'h0, sup = 1'h1;
    logic         tb_wr = 1'h0, xreq = 1'h0, preq = 1'h0, store = 1'h0, ste_direct = 1'h0;
    logic [3:0]   sr_num = 4'h0;
    logic [31:0]  sr_rb = 32'h0, sr_wdata = 32'h0, ea = 32'h0, rdata;
    logic [63:0]  tb_wdata = 64'h0, ste_dw1, tbo, dev, grp;
    logic [4:0]   ste_hash = 5'h00;
    logic [1:0]   idx = 2'h0;
    logic [127:0] pte;
    logic [51:0]  pvsid = {28'h0, 24'hA00002}, svsid, ppn;
    logic         ack, flt, mc, xv, ds, sk, uk, nx, hit, ok, upd, rf, cg, c_ack, c_flt, c_xv, c_hit, c_ok, c_upd;
    logic [8:0]   bus_unit_identifier;
    logic [19:0]  ctrl;
    logic [39:0]  virtual_page_number;
    logic [3:0]   cm;
    int           checks = 0, bad_count = 0, cyc = 0;
    sgpd_top #(.PA_BITS(48), .WIDE_PTE(1)) DUT (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .sr_req_in(sr_req),
        .sr_write_in(sr_write), .sr_indirect_in(sr_ind), .sr_num_in(sr_num), .sr_rb_in(sr_rb), .sr_wdata_in(sr_wdata),
        .supervisor_in(sup), .sr_ack_out(ack), .sr_priv_fault_out(flt), .sr_rdata_out(rdata), .tb_wr_in(tb_wr),
        .tb_wdata_in(tb_wdata), .tb_out(tbo), .machine_check_out(mc), .xlate_req_in(xreq), .eff_addr_in(ea),
        .xlate_valid_out(xv), .direct_store_out(ds), .seg_skey_out(sk), .seg_ukey_out(uk), .seg_noexec_out(nx),
        .bus_unit_id_out(bus_unit_identifier), .ctrl_data_out(ctrl), .vpn32_out(virtual_page_number), .ste_dw1_in(ste_dw1),
        .ste_direct_in(ste_direct), .ste_hash_in(ste_hash), .ste_virtual_segment_identifier_out(svsid), .ste_dev_data_out(dev),
        .group_addr_out(grp), .pte_req_in(preq), .pte_in(pte), .pte_api_in(6'h00), .pte_hash_in(1'h0),
        .access_store_in(store), .pte_hit_out(hit), .ppn_out(ppn), .cache_mode_out(cm), .access_ok_out(ok),
        .pte_upd_out(upd), .pte_ref_out(rf), .pte_chg_out(cg));
    sgpd_table_model u_mem (.idx_in(idx), .virtual_segment_identifier_in(pvsid), .api_in(ea[27:23]), .pte_out(pte), .ste_dw1_out(ste_dw1));
    always #5 clk_sys_in = ~clk_sys_in;
    // ===========================================================
    // request cycle: pulses captured at the answer, then one idle cycle
    // so no request line is lowered and raised in the same time step
    task automatic fire();
        @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        {c_ack, c_flt, c_xv, c_hit, c_ok, c_upd} = {ack, flt, xv, hit, ok, upd};
        {sr_req, tb_wr, xreq, preq} = 4'h0;
        @(negedge clk_sys_in);
    endtask
    task automatic sr_move(input logic wr, input logic ind, input logic [3:0] n, input logic [31:0] d,
                           input logic s);
        {sr_req, sr_write, sr_ind, sup, sr_wdata} = {1'h1, wr, ind, s, d};
        sr_num = ind ? ~n : n;
        sr_rb = ind ? {n, 28'h5A5A5A5} : 32'h0;
        fire();
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            results();
        end
    end
    initial begin
        repeat (12) @(negedge clk_sys_in);
        nrst_in = 1'h1;
        `CHK("base reset", 64'h0, tbo)
        sr_move(1'h0, 1'h0, 4'h5, 32'h0, 1'h1);
        `CHK("seg reset", 32'h0, rdata)
        for (int i = 0; i < 16; i++) begin
            sr_move(1'h1, i[0], i[3:0], {1'h0, i[2:0], 4'hF, 24'hA00000 + 24'(i)}, 1'h1);
            `CHK("write ack", 1'h1, c_ack)
        end
        for (int i = 0; i < 16; i++) begin
            sr_move(1'h0, ~i[0], i[3:0], 32'h0, 1'h1);
            `CHK("seg read", {1'h0, i[2:0], 4'h0, 24'hA00000 + 24'(i)}, rdata)
        end
        sr_move(1'h1, 1'h0, 4'h3, 32'hFFFFFFFF, 1'h0);
        `CHK("user fault", 2'h2, {c_flt, c_ack})
        sr_move(1'h0, 1'h0, 4'h3, 32'h0, 1'h1);
        `CHK("seg kept", {8'h30, 24'hA00003}, rdata)
        sr_move(1'h1, 1'h0, 4'hF, {1'h1, 2'h3, 9'h1A5, 20'hBEEF1}, 1'h1);
        ea = 32'hF0000000;
        xreq = 1'h1;
        fire();
        `CHK("direct store", {1'h1, 9'h1A5, 20'hBEEF1}, {ds, bus_unit_identifier, ctrl})
        ea = 32'h5000F000;
        xreq = 1'h1;
        fire();
        `CHK("key seg", 3'h5, {sk, uk, nx})
        ea = 32'h2ABCD123;
        xreq = 1'h1;
        fire();
        `CHK("page seg", 5'h12, {c_xv, ds, sk, uk, nx})
        `CHK("vpn", {24'hA00002, 16'hABCD}, virtual_page_number)
        for (int i = 0; i < 4; i++) begin
            {idx, store, preq} = {2'(i), i == 0, 1'h1};
            fire();
            `CHK("pte hit", (i == 0 || i == 3), c_hit)
            if (i == 0 || i == 3) begin
                `CHK("ppn", {50'h1_2345_6789, 2'(i)}, ppn)
                `CHK("cache mode", 4'h5, cm)
                `CHK("history", {1'h1, 1'h1, i == 0, i == 0}, {c_ok, rf, cg, c_upd})
            end
        end
        {sup, store, preq} = 3'h3;
        fire();
        `CHK("user store ro", 2'h2, {c_hit, c_ok})
        {sup, idx, ste_hash, tb_wdata, tb_wr} = {1'h1, 2'h0, 5'h15, 64'h0000123456789FFF, 1'h1};
        fire();
        `CHK("base", 65'h0000123456789000, {mc, tbo})
        `CHK("group", {52'h0000123456789, 5'h15, 7'h00}, grp)
        `CHK("ste virtual_segment_identifier", {pvsid, 64'h0}, {svsid, dev})
        {idx, ste_direct} = {2'h3, 1'h1};
        @(negedge clk_sys_in);
        `CHK("ste device", {52'h0, pvsid, 12'hC5A}, {svsid, dev})
        {tb_wdata, tb_wr} = {64'h8000000000000000, 1'h1};
        fire();
        `CHK("machine check", 1'h1, mc)
        {tb_wdata, tb_wr} = {64'h0000000000009000, 1'h1};
        fire();
        `CHK("check sticky", 1'h1, mc)
        results();
    end
endmodule
